// file: timer_defs.svh
// offsets, field positions, reset values and codes of the general timer unit
// Notes on behaviour
// - reset: counters and interval loads read all ones
// - reset: prescale counters and registers read zero
// - config zero is timer32, one is clock32
// - config four splits into independent 16-bit halves
// - 32-bit interval write fills both halves' loads
// - 32-bit count read gives hi:lo concatenation
// - only low half mode field matters in 32-bit
// - combined counter counts down, reloads after zero
// - one-shot stops and clears enable; periodic continues
// - zero sets sticky raw time-out, masked via mask
// - trigger enable pulses converter trigger on zero
// - interval write while running loads counter next cycle
// - freeze bit holds that counter's value
// - selecting clock mode loads up-counter with one
// - divide pin clock to 1 Hz, increment counter
// - clock count equal to match rolls to zero
// - clock match sets raw, masked flags and interrupt
// - keep-running bit overrides freeze bits in clock mode
// - split halves count 16 bits with 8-bit prescaler
// - half at zero reloads interval and prescale, flags
// - prescale p makes each step p+1 clocks
// - mode field one one-shot, two periodic
// - writing one to clear bit clears raw and masked
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define OFS_CFG       8'h00
`define OFS_LO_MODE   8'h04
`define OFS_HI_MODE   8'h08
`define OFS_CTL       8'h0c
`define OFS_MASK      8'h18
`define OFS_RAW       8'h1c
`define OFS_MASKED    8'h20
`define OFS_CLEAR     8'h24
`define OFS_LO_IL     8'h28
`define OFS_HI_IL     8'h2c
`define OFS_LO_MATCH  8'h30
`define OFS_LO_PSR    8'h38
`define OFS_HI_PSR    8'h3c
`define OFS_LO_CNT    8'h48
`define OFS_HI_CNT    8'h4c

`define CFG_TIMER32   3'h0
`define CFG_RTC32     3'h1
`define CFG_SPLIT16   3'h4
`define MODE_ONESHOT  2'h1
`define MODE_PERIODIC 2'h2

`define CTL_RUN       0
`define CTL_FREEZE    1
`define CTL_KEEP      4
`define CTL_TRIG      5
`define CTL_HALF_STEP 8
`define ST_LO_TO      0
`define ST_CLK_MATCH  3
`define ST_HI_TO      8

`define RST_CNT       16'hffff
`define RST_IL        16'hffff
`define RST_PS        8'h00
`define RTC_START     32'h0000_0001
`define DIV_LAST      15'h7fff

`endif

// file: timer_pkg.sv
// types shared by the general timer unit
package timer_pkg;
  typedef enum logic [1:0] {
    UM_TIMER32,
    UM_RTC32,
    UM_SPLIT16,
    UM_IDLE
  } unit_mode_e;
endpackage

// file: general_timer_unit.sv
// general timer unit: two 16-bit halves, 32-bit timer, 1 Hz clock counter, wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module general_timer_unit (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins and events
  input  wire logic        capture_pin_zero,
  output logic             trigger_o,
  output logic             irq_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [2:0]  cfg_q;
  logic [1:0]  mode_q [2];
  logic [15:0] ctl_q, ctl_d;
  logic [15:0] mask_q;
  logic [15:0] raw_q, raw_d;
  logic [15:0] il_q [2];
  logic [15:0] il_d [2];
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic [7:0]  psr_q [2];
  logic [7:0]  psc_q [2];
  logic [7:0]  psc_d [2];
  logic [31:0] match_q;
  logic [14:0] div_q, div_d;
  logic        pin_s1_q, pin_s2_q, pin_s3_q;
  logic        ack_q, trig_q, irq_q;
  logic [31:0] dat_q;
  logic [1:0]  to_evt;
  logic        rtc_evt;

  // bus decode
  // ack_q masks the decode so a request held through its answer is not taken twice
  wire         acc      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire         wr       = acc & wb_we_i;
  wire         wr_cfg   = wr & (wb_adr_i == `OFS_CFG);
  wire         wr_lmode = wr & (wb_adr_i == `OFS_LO_MODE);
  wire         wr_hmode = wr & (wb_adr_i == `OFS_HI_MODE);
  wire         wr_ctl   = wr & (wb_adr_i == `OFS_CTL);
  wire         wr_mask  = wr & (wb_adr_i == `OFS_MASK);
  wire         wr_clr   = wr & (wb_adr_i == `OFS_CLEAR);
  wire         wr_il0   = wr & (wb_adr_i == `OFS_LO_IL);
  wire         wr_il1   = wr & (wb_adr_i == `OFS_HI_IL);
  wire         wr_match = wr & (wb_adr_i == `OFS_LO_MATCH);
  wire         wr_psr0  = wr & (wb_adr_i == `OFS_LO_PSR);
  wire         wr_psr1  = wr & (wb_adr_i == `OFS_HI_PSR);

  wire [31:0]  cfg_nx   = merge({29'h0, cfg_q}, wb_dat_i, wb_sel_i);
  wire [31:0]  clr_bits = merge(32'h0, wb_dat_i, wb_sel_i);
  wire [31:0]  il32     = {il_q[1], il_q[0]};
  wire [31:0]  il32_nx  = merge(il32, wb_dat_i, wb_sel_i);
  wire [31:0]  il0_nx   = merge({16'h0, il_q[0]}, wb_dat_i, wb_sel_i);
  wire [31:0]  il1_nx   = merge({16'h0, il_q[1]}, wb_dat_i, wb_sel_i);
  wire [31:0]  cnt32    = {cnt_q[1], cnt_q[0]};
  wire [31:0]  ctl_nx   = merge({16'h0, ctl_q}, wb_dat_i, wb_sel_i);
  wire [31:0]  mask_nx  = merge({16'h0, mask_q}, wb_dat_i, wb_sel_i);

  timer_pkg::unit_mode_e umode;
  assign umode = (cfg_q == `CFG_TIMER32) ? timer_pkg::UM_TIMER32 :
                 (cfg_q == `CFG_RTC32)   ? timer_pkg::UM_RTC32 :
                 (cfg_q == `CFG_SPLIT16) ? timer_pkg::UM_SPLIT16 :
                                           timer_pkg::UM_IDLE;
  wire         wide     = (umode == timer_pkg::UM_TIMER32) | (umode == timer_pkg::UM_RTC32);
  wire         rtc_sel  = wr_cfg & (cfg_nx[2:0] == `CFG_RTC32) & (cfg_q != `CFG_RTC32);

  // per-half mode decode; the combined timer reads the low field only
  wire [1:0]   oneshot  = {mode_q[1] == `MODE_ONESHOT, mode_q[0] == `MODE_ONESHOT};
  wire [1:0]   counting = oneshot | {mode_q[1] == `MODE_PERIODIC,
                                     mode_q[0] == `MODE_PERIODIC};
  wire [1:0]   run      = {ctl_q[`CTL_RUN + `CTL_HALF_STEP], ctl_q[`CTL_RUN]};
  wire [1:0]   frz      = {ctl_q[`CTL_FREEZE + `CTL_HALF_STEP], ctl_q[`CTL_FREEZE]};
  wire [1:0]   trig_en  = {ctl_q[`CTL_TRIG + `CTL_HALF_STEP], ctl_q[`CTL_TRIG]};
  wire         rtc_hold = (|frz) & ~ctl_q[`CTL_KEEP];

  // pin clock: two flops before use, third only for the edge
  wire         pin_rise = pin_s2_q & ~pin_s3_q;
  wire         rtc_go   = (umode == timer_pkg::UM_RTC32) & run[0];
  wire         tick     = rtc_go & pin_rise & (div_q == `DIV_LAST);

  always_comb begin
    div_d = '0;
    if (rtc_go) begin
      div_d = pin_rise ? div_q + 15'h1 : div_q;
    end
  end

  always_comb begin
    cnt_d   = cnt_q;
    psc_d   = psc_q;
    ctl_d   = wr_ctl ? ctl_nx[15:0] : ctl_q;
    to_evt  = 2'b00;
    rtc_evt = 1'b0;
    unique case (umode)
      timer_pkg::UM_TIMER32: begin
        if (wr_il0) begin
          {cnt_d[1], cnt_d[0]} = il32_nx;
        end else if (run[0] && !frz[0] && counting[0]) begin
          if (cnt32 == 32'h0) begin
            {cnt_d[1], cnt_d[0]} = il32;
            to_evt[0] = 1'b1;
            if (oneshot[0]) begin
              ctl_d[`CTL_RUN] = 1'b0;
            end
          end else begin
            {cnt_d[1], cnt_d[0]} = cnt32 - 32'h1;
          end
        end
      end
      timer_pkg::UM_RTC32: begin
        if (tick && !rtc_hold) begin
          if (cnt32 == match_q) begin
            {cnt_d[1], cnt_d[0]} = 32'h0;
            rtc_evt = 1'b1;
          end else begin
            {cnt_d[1], cnt_d[0]} = cnt32 + 32'h1;
          end
        end
      end
      timer_pkg::UM_SPLIT16: begin
        for (int h = 0; h < 2; h++) begin
          if ((h == 0) ? wr_il0 : wr_il1) begin
            cnt_d[h] = (h == 0) ? il0_nx[15:0] : il1_nx[15:0];
            psc_d[h] = psr_q[h];
          end else if (run[h] && !frz[h] && counting[h]) begin
            if (psc_q[h] != 8'h0) begin
              psc_d[h] = psc_q[h] - 8'h1;
            end else if (cnt_q[h] == 16'h0) begin
              cnt_d[h] = il_q[h];
              psc_d[h] = psr_q[h];
              to_evt[h] = 1'b1;
              if (oneshot[h]) begin
                ctl_d[`CTL_RUN + h * `CTL_HALF_STEP] = 1'b0;
              end
            end else begin
              cnt_d[h] = cnt_q[h] - 16'h1;
              psc_d[h] = psr_q[h];
            end
          end
        end
      end
      timer_pkg::UM_IDLE: begin
      end
    endcase
    if (rtc_sel) begin
      {cnt_d[1], cnt_d[0]} = `RTC_START;
    end
  end

  // interval loads: a 32-bit write lands in both halves in the wide modes
  always_comb begin
    il_d = il_q;
    if (wide && wr_il0) begin
      {il_d[1], il_d[0]} = il32_nx;
    end else begin
      if (wr_il0) begin
        il_d[0] = il0_nx[15:0];
      end
      if (wr_il1) begin
        il_d[1] = il1_nx[15:0];
      end
    end
  end

  // set beats clear so a time-out on the clearing edge is kept
  always_comb begin
    raw_d = (raw_q & ~(wr_clr ? clr_bits[15:0] : 16'h0));
    raw_d[`ST_LO_TO]     = raw_d[`ST_LO_TO] | to_evt[0];
    raw_d[`ST_HI_TO]     = raw_d[`ST_HI_TO] | to_evt[1];
    raw_d[`ST_CLK_MATCH] = raw_d[`ST_CLK_MATCH] | rtc_evt;
  end

  // read mux
  wire [15:0] masked = raw_q & mask_q;
  wire [31:0] rdata =
    (wb_adr_i == `OFS_CFG)      ? {29'h0, cfg_q} :
    (wb_adr_i == `OFS_LO_MODE)  ? {30'h0, mode_q[0]} :
    (wb_adr_i == `OFS_HI_MODE)  ? {30'h0, mode_q[1]} :
    (wb_adr_i == `OFS_CTL)      ? {16'h0, ctl_q} :
    (wb_adr_i == `OFS_MASK)     ? {16'h0, mask_q} :
    (wb_adr_i == `OFS_RAW)      ? {16'h0, raw_q} :
    (wb_adr_i == `OFS_MASKED)   ? {16'h0, masked} :
    (wb_adr_i == `OFS_LO_IL)    ? (wide ? il32 : {16'h0, il_q[0]}) :
    (wb_adr_i == `OFS_HI_IL)    ? {16'h0, il_q[1]} :
    (wb_adr_i == `OFS_LO_MATCH) ? match_q :
    (wb_adr_i == `OFS_LO_PSR)   ? {24'h0, psr_q[0]} :
    (wb_adr_i == `OFS_HI_PSR)   ? {24'h0, psr_q[1]} :
    (wb_adr_i == `OFS_LO_CNT)   ? (wide ? cnt32 : {16'h0, cnt_q[0]}) :
    (wb_adr_i == `OFS_HI_CNT)   ? {16'h0, cnt_q[1]} :
                                  32'h0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      div_q    <= '0;
    end else begin
      pin_s1_q <= capture_pin_zero;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      div_q    <= div_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int h = 0; h < 2; h++) begin
        cnt_q[h]  <= `RST_CNT;
        il_q[h]   <= `RST_IL;
        psc_q[h]  <= `RST_PS;
        psr_q[h]  <= `RST_PS;
        mode_q[h] <= '0;
      end
      cfg_q   <= `CFG_TIMER32;
      ctl_q   <= '0;
      mask_q  <= '0;
      raw_q   <= '0;
      match_q <= '0;
    end else begin
      cnt_q   <= cnt_d;
      il_q    <= il_d;
      psc_q   <= psc_d;
      ctl_q   <= ctl_d;
      raw_q   <= raw_d;
      cfg_q   <= wr_cfg ? cfg_nx[2:0] : cfg_q;
      mask_q  <= wr_mask ? mask_nx[15:0] : mask_q;
      match_q <= wr_match ? merge(match_q, wb_dat_i, wb_sel_i) : match_q;
      psr_q[0]  <= (wr_psr0 && wb_sel_i[0]) ? wb_dat_i[7:0] : psr_q[0];
      psr_q[1]  <= (wr_psr1 && wb_sel_i[0]) ? wb_dat_i[7:0] : psr_q[1];
      mode_q[0] <= (wr_lmode && wb_sel_i[0]) ? wb_dat_i[1:0] : mode_q[0];
      mode_q[1] <= (wr_hmode && wb_sel_i[0]) ? wb_dat_i[1:0] : mode_q[1];
    end
  end

  // answers and event outputs, all registered
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q  <= 1'b0;
      dat_q  <= '0;
      trig_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      ack_q  <= acc;
      dat_q  <= acc ? rdata : dat_q;
      trig_q <= |(to_evt & trig_en);
      irq_q  <= |(raw_d & mask_q);
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;
  assign trigger_o = trig_q;
  assign irq_o     = irq_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // the combined timer at zero, free to reload this cycle
  sequence s_zero32;
    umode == timer_pkg::UM_TIMER32 && run[0] && !frz[0] && counting[0] && !wr_il0
      && !rtc_sel && cnt32 == 32'h0;
  endsequence
  // the high half at zero with its prescaler spent
  sequence s_zero16_hi;
    umode == timer_pkg::UM_SPLIT16 && run[1] && !frz[1] && counting[1] && !wr_il1
      && !rtc_sel && psc_q[1] == 8'h0 && cnt_q[1] == 16'h0;
  endsequence

  // register bus: one answer per request, one cycle long
  a_bus_answer: assert property (acc |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held longer than one cycle");

  // reset values
  a_reset_counts: assert property (@(posedge mclk) disable iff (1'b0)
      $rose(reset_n) |-> (cnt32 == {`RST_CNT, `RST_CNT}) && (il32 == {`RST_IL, `RST_IL}))
    else $error("counters or interval loads not all ones after reset");
  a_reset_prescale: assert property (@(posedge mclk) disable iff (1'b0)
      $rose(reset_n) |-> (psc_q[0] == `RST_PS) && (psc_q[1] == `RST_PS)
        && (psr_q[0] == `RST_PS) && (psr_q[1] == `RST_PS))
    else $error("prescale not zero after reset");

  // config decode and wide timer
  a_cfg_split: assert property (wr_cfg && wb_sel_i[0]
      && wb_dat_i[2:0] == `CFG_SPLIT16 |=> umode == timer_pkg::UM_SPLIT16)
    else $error("config four did not split the halves");
  a_il_wide: assert property (wide && wr_il0 && wb_sel_i == 4'hf
      |=> il_q[1] == $past(wb_dat_i[31:16]) && il_q[0] == $past(wb_dat_i[15:0]))
    else $error("wide interval write not spread over both halves");
  a_cnt_read: assert property (acc && !wb_we_i && wide && wb_adr_i == `OFS_LO_CNT
      |=> wb_ack_o && wb_dat_o == {$past(cnt_q[1]), $past(cnt_q[0])})
    else $error("wide count read not hi:lo");
  a_il_load: assert property (umode == timer_pkg::UM_TIMER32 && wr_il0
      && wb_sel_i == 4'hf && !rtc_sel |=> cnt32 == $past(wb_dat_i))
    else $error("interval write did not load the counter");
  a_reload32: assert property (s_zero32 |=> cnt32 == $past(il32))
    else $error("combined counter did not reload after zero");
  a_oneshot_stop: assert property ((s_zero32 and (oneshot[0] && !wr_ctl && !wr_cfg))
      |=> !ctl_q[`CTL_RUN] ##1 ($stable(cnt32) || $past(wr_il0) || $past(rtc_sel)))
    else $error("one-shot kept running after zero");
  a_periodic_run: assert property ((s_zero32 and (counting[0] && !oneshot[0] && !wr_ctl))
      |=> ctl_q[`CTL_RUN])
    else $error("periodic counter stopped at zero");
  a_trigger_pulse: assert property ((s_zero32 and trig_en[0]) |=> trigger_o)
    else $error("trigger missing on time-out");
  a_freeze_hold: assert property (umode == timer_pkg::UM_TIMER32 && frz[0] && !wr_il0
      && !rtc_sel |=> $stable(cnt32))
    else $error("frozen counter moved");

  // clock mode
  a_rtc_start: assert property (rtc_sel |=> cnt32 == `RTC_START)
    else $error("clock mode did not start from one");
  a_rtc_match: assert property (tick && !rtc_hold && !rtc_sel && cnt32 == match_q
      |=> cnt32 == 32'h0 && raw_q[`ST_CLK_MATCH])
    else $error("clock match did not roll to zero");
  a_rtc_keep: assert property (tick && ctl_q[`CTL_KEEP] && !rtc_sel
      |=> cnt32 == (($past(cnt32) == $past(match_q)) ? 32'h0 : $past(cnt32) + 32'h1))
    else $error("keep-running clock counter stalled");

  // split halves
  a_split_reload: assert property (s_zero16_hi |=> cnt_q[1] == $past(il_q[1])
      && psc_q[1] == $past(psr_q[1]) && raw_q[`ST_HI_TO])
    else $error("split half did not reload or flag at zero");
  a_split_step: assert property (umode == timer_pkg::UM_SPLIT16 && run[0] && !frz[0]
      && counting[0] && psc_q[0] == 8'h0 && cnt_q[0] != 16'h0 && !wr_il0 && !rtc_sel
      |=> cnt_q[0] == $past(cnt_q[0]) - 16'h1 && psc_q[0] == $past(psr_q[0]))
    else $error("split half did not step down");
  a_prescale_step: assert property (umode == timer_pkg::UM_SPLIT16 && run[0] && !frz[0]
      && counting[0] && psc_q[0] != 8'h0 && !wr_il0 && !rtc_sel |=> $stable(cnt_q[0]))
    else $error("half stepped before prescale ran out");

  // status flags and interrupt
  a_timeout_flag: assert property (s_zero32 |=> raw_q[`ST_LO_TO]
      ##1 (raw_q[`ST_LO_TO] || $past(wr_clr)))
    else $error("time-out flag not set or not held");
  a_irq_level: assert property (|(raw_q & mask_q) && !wr_clr
      |=> irq_o)
    else $error("interrupt low while a masked flag stands");
  a_clear_flag: assert property (wr_clr && clr_bits[`ST_LO_TO] && !to_evt[0]
      |=> !raw_q[`ST_LO_TO] && !masked[`ST_LO_TO])
    else $error("clear write left the time-out flag set");
  a_clear_zero: assert property (wr_clr && !clr_bits[`ST_LO_TO] && raw_q[`ST_LO_TO]
      |=> raw_q[`ST_LO_TO])
    else $error("zero clear write dropped the time-out flag");

endmodule
`default_nettype wire

// file: cap_clock_src.sv
// behavioural slow-clock source that drives the capture pin
`timescale 1ns/10ps
`default_nettype none

module cap_clock_src #(
  parameter int HALF_NS = 10
) (
  // capture pin
  output logic pin
);

  // time-scaled to one rise per two mclk cycles so that a whole 1 Hz tick fits the run
  initial begin
    pin = 1'b0;
    #3;
    forever #HALF_NS pin = ~pin;
  end

endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the general timer unit
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module tb_top;

  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  wire logic [31:0] rdat;
  wire logic   ack;
  wire logic   pin;
  wire logic   trig;
  wire logic   irq;
  int          fails = 0;
  int          n_checks = 0;
  int          seed = 23078;
  logic [31:0] q;
  logic [31:0] r;
  int          n;
  int          p;
  int          t0;
  int          t1;

  always #5 mclk = ~mclk;

  general_timer_unit dut (
    .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .capture_pin_zero(pin), .trigger_o(trig), .irq_o(irq)
  );

  cap_clock_src src (.pin(pin));

  function automatic int step_cycles(int cnt, int ps);
    return (cnt + 1) * (ps + 1);
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  // request held until ack is sampled high, then released for a cycle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    chk_val(q, e);
  endtask

  task automatic wait_trig(input int lim, output int c);
    c = 0;
    while (trig !== 1'b1 && c < lim) begin
      @(posedge mclk);
      c++;
    end
    if (c >= lim) fails++;
  endtask

  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd_chk(`OFS_LO_CNT, 32'hffff_ffff);
    rd_chk(`OFS_LO_IL, 32'hffff_ffff);
    rd_chk(`OFS_HI_CNT, {16'h0, `RST_CNT});
    rd_chk(`OFS_CTL, 32'h0);
    rd_chk(`OFS_LO_PSR, {24'h0, `RST_PS});
    rd_chk(`OFS_HI_PSR, {24'h0, `RST_PS});
    wr(8'h7c, 32'hffff_ffff);
    rd_chk(8'h7c, 32'h0);
    wr(`OFS_RAW, 32'hffff_ffff);
    rd_chk(`OFS_RAW, 32'h0);
    r = $random(seed);
    wr(`OFS_LO_IL, r);
    rd_chk(`OFS_HI_IL, {16'h0, r[31:16]});
    rd_chk(`OFS_LO_CNT, r);
    rd_chk(`OFS_HI_CNT, {16'h0, r[31:16]});
    done_test("reset and wide access");
    // one-shot; the hi mode field asks for periodic and must not matter
    n = 4 + ($random(seed) & 15);
    wr(`OFS_LO_MODE, {30'h0, `MODE_ONESHOT});
    wr(`OFS_HI_MODE, {30'h0, `MODE_PERIODIC});
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_LO_IL, n);
    wr(`OFS_CTL, 32'h21);
    wait_trig(n + 10, t0);
    chk_pin(t0 inside {[n - 2:n + 3]}, 1'b1);
    repeat (4) @(posedge mclk);
    rd_chk(`OFS_CTL, 32'h20);
    rd_chk(`OFS_LO_CNT, n);
    rd_chk(`OFS_RAW, 32'h1);
    rd_chk(`OFS_MASKED, 32'h1);
    chk_pin(irq, 1'b1);
    wr(`OFS_CLEAR, 32'h0);
    rd_chk(`OFS_RAW, 32'h1);
    wr(`OFS_CLEAR, 32'h1);
    rd_chk(`OFS_RAW, 32'h0);
    rd_chk(`OFS_MASKED, 32'h0);
    chk_pin(irq, 1'b0);
    done_test("one-shot");
    wr(`OFS_LO_MODE, {30'h0, `MODE_PERIODIC});
    wr(`OFS_CTL, 32'h21);
    wait_trig(n + 10, t0);
    @(posedge mclk);
    wait_trig(n + 10, t1);
    chk_val(t1 + 1, n + 1);
    rd_chk(`OFS_CTL, 32'h21);
    wr(`OFS_LO_IL, 32'h0000_1000);
    wb_xfer(1'b0, `OFS_LO_CNT, 32'h0);
    chk_pin(q <= 32'h1000 && q >= 32'h0ff8, 1'b1);
    wr(`OFS_CTL, 32'h23);
    wb_xfer(1'b0, `OFS_LO_CNT, 32'h0);
    r = q;
    repeat (10) @(posedge mclk);
    rd_chk(`OFS_LO_CNT, r);
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_CLEAR, 32'h1);
    done_test("periodic and freeze");
    // split halves; prescale at both ends of its range and one random value
    wr(`OFS_CFG, {29'h0, `CFG_SPLIT16});
    wr(`OFS_HI_MODE, {30'h0, `MODE_ONESHOT});
    wr(`OFS_HI_IL, 32'h5);
    for (int i = 0; i < 3; i++) begin
      n = 3 + ($random(seed) & 7);
      p = (i == 0) ? 0 : (i == 1) ? 255 : ($random(seed) & 255);
      wr(`OFS_LO_PSR, p);
      wr(`OFS_LO_IL, n);
      wr(`OFS_CTL, 32'h121);
      wait_trig(2 * step_cycles(n, p) + 20, t0);
      @(posedge mclk);
      wait_trig(step_cycles(n, p) + 20, t1);
      chk_val(t1 + 1, step_cycles(n, p));
    end
    rd_chk(`OFS_CTL, 32'h21);
    rd_chk(`OFS_HI_CNT, 32'h5);
    rd_chk(`OFS_RAW, 32'h101);
    wr(`OFS_CLEAR, 32'h100);
    rd_chk(`OFS_RAW, 32'h1);
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_CLEAR, 32'h109);
    done_test("split halves");
    // a config code with no mode behind it must leave the low counter still
    wr(`OFS_CFG, 32'h2);
    wr(`OFS_CTL, 32'h101);
    wb_xfer(1'b0, `OFS_LO_CNT, 32'h0);
    r = q;
    repeat (5) @(posedge mclk);
    rd_chk(`OFS_LO_CNT, r);
    wr(`OFS_CTL, 32'h0);
    done_test("unused config code");
    // clock mode with both freeze bits set but keep-running on
    wr(`OFS_CFG, {29'h0, `CFG_RTC32});
    rd_chk(`OFS_LO_CNT, `RTC_START);
    wr(`OFS_LO_MATCH, 32'h1);
    wr(`OFS_MASK, 32'h8);
    wr(`OFS_CTL, 32'h213);
    t0 = 0;
    while (irq !== 1'b1 && t0 < 70000) begin
      @(posedge mclk);
      t0++;
    end
    chk_pin(t0 inside {[65520:65560]}, 1'b1);
    rd_chk(`OFS_LO_CNT, 32'h0);
    rd_chk(`OFS_RAW, 32'h8);
    rd_chk(`OFS_MASKED, 32'h8);
    wr(`OFS_CLEAR, 32'h8);
    rd_chk(`OFS_RAW, 32'h0);
    chk_pin(irq, 1'b0);
    done_test("clock mode");
    print_verdict();
  end

  // the clock-mode tick alone needs about 65536 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    print_verdict();
  end

endmodule

`default_nettype wire
